// file: inc/pmw_consts.svh
`ifndef PMW_CONSTS_SVH
`define PMW_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define PMW_ADDR_MODE    12'h000
`define PMW_ADDR_WARN    12'h004
`define PMW_ADDR_STATUS  12'h008
`define PMW_ADDR_W       12

// ----------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------
`define PMW_REG_CTRL_BIT  7
`define PMW_STBY_STAT_BIT 6
`define PMW_WAKE_BIT      5
`define PMW_RECOV_BIT     3
`define PMW_RECOV_ACK_BIT 2
`define PMW_PD_EN_BIT     1
`define PMW_STOP_BIT      0

// ----------------------------------------------------------------------
// Warning register fields
// ----------------------------------------------------------------------
`define PMW_WFLAG_BIT    7
`define PMW_WACK_BIT     6
`define PMW_DSEL_BIT     5
`define PMW_WSEL_BIT     4
`define PMW_WIE_BIT      3

// ----------------------------------------------------------------------
// Reset values and bus transfer codes
// ----------------------------------------------------------------------
`define PMW_PD_EN_RESET  1'b1
`define PMW_ZERO8        8'h00
`define PMW_ZERO32       32'h0000_0000
`define PMW_HTRANS_NSEQ  2'b10
`define PMW_HSIZE_WORD   3'b010

`endif

// file: inc/pmw_pkg.sv
package pmw_pkg;

  typedef enum logic [2:0] {
    PMW_RUN   = 3'b001,
    PMW_STBY  = 3'b010,
    PMW_STOP  = 3'b100
  } pmw_mode_type;

endpackage

// file: sim/pmw_tb_top.sv
`include "pmw_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module power_mode_and_lv_warning_ctrl_tb_top;

  // ------------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdat;
    logic [31:0] rdat;
  } pmw_row_type;

  logic        hclk               = 1'b0;
  logic        hresetn            = 1'b0;
  logic        hsel               = 1'b0;
  logic [31:0] haddr              = 32'h0000_0000;
  logic [1:0]  htrans             = 2'b00;
  logic        hwrite             = 1'b0;
  logic [2:0]  hsize              = 3'b000;
  logic [31:0] hwdata             = 32'h0000_0000;
  logic        hready             = 1'b1;
  logic        lv_warning_present = 1'b0;
  logic        irq_pending        = 1'b0;
  logic        stop_request       = 1'b0;
  logic        stop_wakeup        = 1'b0;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         lp_run;
  wire         lp_wait;
  wire         stby;
  wire         stop2;
  wire         stop3;
  wire         dvs;
  wire         wvs;
  wire         lvw_irq;
  int          error_cnt          = 0;
  int          num_checks         = 0;
  int          cyc                = 0;
  pmw_row_type rows [5];

  always #5 hclk = ~hclk;

  pmw_top DUT (
    .hclk                   (hclk),
    .hresetn                (hresetn),
    .hsel                   (hsel),
    .haddr                  (haddr),
    .htrans                 (htrans),
    .hwrite                 (hwrite),
    .hsize                  (hsize),
    .hwdata                 (hwdata),
    .hready                 (hready),
    .hrdata                 (hrdata),
    .hreadyout              (hreadyout),
    .hresp                  (hresp),
    .lv_warning_present     (lv_warning_present),
    .irq_pending            (irq_pending),
    .stop_request           (stop_request),
    .stop_wakeup            (stop_wakeup),
    .low_power_run_mode     (lp_run),
    .low_power_wait_mode    (lp_wait),
    .regulator_standby      (stby),
    .stop2_active           (stop2),
    .stop3_active           (stop3),
    .detect_voltage_select  (dvs),
    .warning_voltage_select (wvs),
    .lv_warning_irq         (lvw_irq)
  );

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // One whole-word transfer; the slave may stretch either phase.
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h0_0000, a};
    htrans <= `PMW_HTRANS_NSEQ;
    hwrite <= wr;
    hsize  <= `PMW_HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? wd : 32'h0000_0000;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0000_0000, v);
    chk(v, exp);
  endtask

  // Pins pass a two-flop synchroniser, so allow a few cycles to settle.
  task automatic settle();
    repeat (6) @(posedge hclk);
  endtask

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    rows[0] = '{`PMW_ADDR_WARN, 32'hffff_ffff, 32'h0000_0038};
    rows[1] = '{`PMW_ADDR_WARN, 32'h0000_0010, 32'h0000_0010};
    rows[2] = '{`PMW_ADDR_WARN, 32'h0000_0030, 32'h0000_0030};
    rows[3] = '{`PMW_ADDR_WARN, 32'h0000_0000, 32'h0000_0000};
    rows[4] = '{`PMW_ADDR_STATUS, 32'h0000_00ff, 32'h0000_0000};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(`PMW_ADDR_MODE, 32'h0000_0002);
    rdchk(`PMW_ADDR_WARN, 32'h0000_0000);
    chk(32'(hresp), 32'h0000_0000);
    chk(32'(hreadyout), 32'h0000_0001);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdat);
      rdchk(rows[i].addr, rows[i].rdat);
      chk(32'({dvs, wvs}), 32'(rows[i].rdat[5:4]));
    end
    wr(`PMW_ADDR_MODE, 32'h0000_0083);
    rdchk(`PMW_ADDR_MODE, 32'h0000_0003);
    stop_request <= 1'b1;
    settle();
    chk(32'({stop2, stop3}), 32'h0000_0002);
    stop_wakeup  <= 1'b1;
    stop_request <= 1'b0;
    settle();
    stop_wakeup  <= 1'b0;
    rdchk(`PMW_ADDR_MODE, 32'h0000_000b);
    // Enable-once was spent by the first write, so bit 1 = 0 is ignored.
    wr(`PMW_ADDR_MODE, 32'h0000_0085);
    rdchk(`PMW_ADDR_MODE, 32'h0000_0003);
    wr(`PMW_ADDR_MODE, 32'h0000_0002);
    stop_request <= 1'b1;
    settle();
    chk(32'({stop2, stop3}), 32'h0000_0001);
    stop_wakeup  <= 1'b1;
    stop_request <= 1'b0;
    settle();
    stop_wakeup  <= 1'b0;
    rdchk(`PMW_ADDR_MODE, 32'h0000_0002);
    wr(`PMW_ADDR_MODE, 32'h0000_0082);
    settle();
    rdchk(`PMW_ADDR_MODE, 32'h0000_00c2);
    chk(32'({stby, lp_run, lp_wait}), 32'h0000_0006);
    stop_request <= 1'b1;
    settle();
    chk(32'({lp_run, lp_wait}), 32'h0000_0001);
    stop_request <= 1'b0;
    wr(`PMW_ADDR_MODE, 32'h0000_0083);
    rdchk(`PMW_ADDR_MODE, 32'h0000_00c2);
    irq_pending <= 1'b1;
    settle();
    rdchk(`PMW_ADDR_MODE, 32'h0000_00c2);
    irq_pending <= 1'b0;
    wr(`PMW_ADDR_MODE, 32'h0000_00a2);
    settle();
    rdchk(`PMW_ADDR_MODE, 32'h0000_00e2);
    irq_pending <= 1'b1;
    settle();
    rdchk(`PMW_ADDR_MODE, 32'h0000_0022);
    chk(32'(stby), 32'h0000_0000);
    irq_pending <= 1'b0;
    lv_warning_present <= 1'b1;
    settle();
    wr(`PMW_ADDR_WARN, 32'h0000_0048);
    rdchk(`PMW_ADDR_WARN, 32'h0000_0088);
    chk(32'(lvw_irq), 32'h0000_0001);
    lv_warning_present <= 1'b0;
    settle();
    rdchk(`PMW_ADDR_WARN, 32'h0000_0088);
    wr(`PMW_ADDR_WARN, 32'h0000_0048);
    rdchk(`PMW_ADDR_WARN, 32'h0000_0008);
    chk(32'(lvw_irq), 32'h0000_0000);
    // A second reset with the supply already low must raise the flag.
    lv_warning_present <= 1'b1;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    rdchk(`PMW_ADDR_WARN, 32'h0000_0080);
    wr(`PMW_ADDR_MODE, 32'h0000_0000);
    wr(`PMW_ADDR_MODE, 32'h0000_0003);
    rdchk(`PMW_ADDR_MODE, 32'h0000_0000);
    close_out();
  end

endmodule

`default_nettype wire

// file: src/pmw_edge.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Rising-edge pulse of a synchronised level
// ----------------------------------------------------------------------
module pmw_edge (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic din,
  output var  logic rise
);

  logic last_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_q <= 1'b0;
    end else begin
      last_q <= din;
    end
  end

  assign rise = din & ~last_q;

endmodule

`default_nettype wire

// file: src/pmw_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Two-stage synchroniser for one level
// ----------------------------------------------------------------------
module pmw_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic din,
  output var  logic dout
);

  logic meta_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

`default_nettype wire

// file: src/pmw_top.sv
// Function
// - Setting the regulator control bit is ignored while stop select is 1.
// - Writing both regulator control and stop select sets only stop select.
// - Any interrupt clears regulator control when wake-on-interrupt is 1; here a write that sets it in the same cycle wins.
// - Regulator control 1 enables low-power run and wait; 0 disables both.
// - Bit 6 reads 1 while the regulator is in standby.
// - Wake-on-interrupt 1 leaves standby on interrupt; 0 stays in standby.
// - Recovery flag at bit 3 sets after recovery from stop2.
// - Writing 1 to acknowledge bit 2 clears the recovery flag.
// - Partial power-down enable takes one write after reset; 0 disables.
// - Setting stop select is ignored while regulator control is 1.
// - Stop select may become 1 only while partial power-down enable is 1.
// - Stop select 0 chooses stop3; 1 chooses stop2.
// - Warning flag sets when supply falls below the trip, also after reset.
// - Warning flag is sticky until software acknowledges it.
// - Acknowledge clears the flag only when no warning is present; reads 0.
// - Detect select bit 5 picks low or high detect trip point.
// - Warning select bit 4 picks low or high warning trip point.
// - Interrupt enable 1 requests an interrupt whenever the flag is 1.
//
// Our own choices: the AHB-Lite register port and the register addresses.
`include "pmw_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pmw_top (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output var  logic [31:0]  hrdata,
  output var  logic         hreadyout,
  output var  logic         hresp,
  input  wire logic         lv_warning_present,
  input  wire logic         irq_pending,
  input  wire logic         stop_request,
  input  wire logic         stop_wakeup,
  output var  logic         low_power_run_mode,
  output var  logic         low_power_wait_mode,
  output var  logic         regulator_standby,
  output var  logic         stop2_active,
  output var  logic         stop3_active,
  output var  logic         detect_voltage_select,
  output var  logic         warning_voltage_select,
  output var  logic         lv_warning_irq
);
  import pmw_pkg::*;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    logic                     wr_pend;
    logic [`PMW_ADDR_W-1:0]   wr_addr;
    logic [31:0]              rdata;
    logic                     reg_ctrl;
    logic                     wake;
    logic                     recov;
    logic                     pd_en;
    logic                     pd_en_locked;
    logic                     stop_sel;
    logic                     wflag;
    logic                     dsel;
    logic                     wsel;
    logic                     wie;
    pmw_mode_type             mode;
    logic                     lp_run;
    logic                     lp_wait;
    logic                     s2;
    logic                     s3;
    logic                     irq;
  } pmw_state_type;

  pmw_state_type s_q;
  pmw_state_type s_d;

  logic warn_s;
  logic irq_s;
  logic stopreq_s;
  logic wake_s;
  logic warn_rise;

  // Every pin from outside the bus domain passes two flops first.
  pmw_sync u_sync_warn (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (lv_warning_present),
    .dout    (warn_s)
  );
  pmw_sync u_sync_irq (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (irq_pending),
    .dout    (irq_s)
  );
  pmw_sync u_sync_stop (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (stop_request),
    .dout    (stopreq_s)
  );
  pmw_sync u_sync_wake (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (stop_wakeup),
    .dout    (wake_s)
  );
  pmw_edge u_edge_warn (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (warn_s),
    .rise    (warn_rise)
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  logic       addr_ok;
  logic       do_wr;
  logic       wr_mode;
  logic       wr_warn;
  logic [7:0] wb;
  logic       set_reg;
  logic       set_stop;
  logic [7:0] mode_rd;
  logic [7:0] warn_rd;

  always_comb begin
    s_d      = s_q;
    addr_ok  = hsel & hready & (htrans == `PMW_HTRANS_NSEQ);
    do_wr    = s_q.wr_pend;
    wb       = hwdata[7:0];
    wr_mode  = do_wr & (s_q.wr_addr == `PMW_ADDR_MODE);
    wr_warn  = do_wr & (s_q.wr_addr == `PMW_ADDR_WARN);
    set_reg  = 1'b0;
    set_stop = 1'b0;

    s_d.wr_pend = addr_ok & hwrite;
    s_d.wr_addr = haddr[`PMW_ADDR_W-1:0];

    // Register writes; a set of stop select in the same write outranks regulator control.
    if (wr_mode) begin
      s_d.wake = wb[`PMW_WAKE_BIT];
      set_stop = wb[`PMW_STOP_BIT] & ~s_q.reg_ctrl
               & s_q.pd_en;
      // A stop select that passes the reg_ctrl and pd_en gates blocks regulator control, even if a first write with bit 1 = 0 then clears it.
      set_reg  = wb[`PMW_REG_CTRL_BIT] & ~s_q.stop_sel
               & ~set_stop;
      s_d.stop_sel = set_stop | (wb[`PMW_STOP_BIT] & s_q.stop_sel);
      s_d.reg_ctrl = set_reg;
      if (!s_q.pd_en_locked) begin
        s_d.pd_en        = wb[`PMW_PD_EN_BIT];
        s_d.pd_en_locked = 1'b1;
      end
      if (!wb[`PMW_PD_EN_BIT] && !s_q.pd_en_locked) begin
        s_d.stop_sel = 1'b0;
      end
      if (wb[`PMW_RECOV_ACK_BIT]) begin
        s_d.recov = 1'b0;
      end
    end

    if (wr_warn) begin
      // Bits 2..0 are simply not stored.
      s_d.dsel = wb[`PMW_DSEL_BIT];
      s_d.wsel = wb[`PMW_WSEL_BIT];
      s_d.wie  = wb[`PMW_WIE_BIT];
      if (wb[`PMW_WACK_BIT] && !warn_s) begin
        s_d.wflag = 1'b0;
      end
    end

    // Hardware sets win over software clears.
    if (warn_rise || warn_s) begin
      s_d.wflag = 1'b1;
    end

    // Power mode sequencing.
    case (s_q.mode)
      PMW_RUN: begin
        if (stopreq_s) begin
          s_d.mode = PMW_STOP;
        end else if (s_q.reg_ctrl) begin
          s_d.mode = PMW_STBY;
        end
      end
      PMW_STBY: begin
        if (irq_s && s_q.wake) begin
          s_d.mode = PMW_RUN;
        end else if (!s_q.reg_ctrl) begin
          s_d.mode = PMW_RUN;
        end
      end
      PMW_STOP: begin
        if (wake_s) begin
          s_d.mode = PMW_RUN;
          if (s_q.stop_sel) begin
            s_d.recov = 1'b1;
          end
        end
      end
      default: begin
        s_d.mode = PMW_RUN;
      end
    endcase

    if (irq_s && s_q.wake && !set_reg) begin
      s_d.reg_ctrl = 1'b0;
    end

    s_d.lp_run  = (s_d.mode == PMW_STBY) & ~stopreq_s;
    s_d.lp_wait = (s_d.mode == PMW_STBY) & stopreq_s;
    s_d.s2      = (s_d.mode == PMW_STOP) & s_d.stop_sel;
    s_d.s3      = (s_d.mode == PMW_STOP) & ~s_d.stop_sel;
    s_d.irq     = s_d.wflag & s_d.wie;

    // Read data; acknowledge bits always read 0.
    mode_rd = `PMW_ZERO8;
    mode_rd[`PMW_REG_CTRL_BIT]  = s_q.reg_ctrl;
    mode_rd[`PMW_STBY_STAT_BIT] = (s_q.mode == PMW_STBY);
    mode_rd[`PMW_WAKE_BIT]      = s_q.wake;
    mode_rd[`PMW_RECOV_BIT]     = s_q.recov;
    mode_rd[`PMW_PD_EN_BIT]     = s_q.pd_en;
    mode_rd[`PMW_STOP_BIT]      = s_q.stop_sel;
    warn_rd = `PMW_ZERO8;
    warn_rd[`PMW_WFLAG_BIT] = s_q.wflag;
    warn_rd[`PMW_DSEL_BIT]  = s_q.dsel;
    warn_rd[`PMW_WSEL_BIT]  = s_q.wsel;
    warn_rd[`PMW_WIE_BIT]   = s_q.wie;

    s_d.rdata = `PMW_ZERO32;
    if (addr_ok && !hwrite) begin
      case (haddr[`PMW_ADDR_W-1:0])
        `PMW_ADDR_MODE: begin
          s_d.rdata = {24'h00_0000, mode_rd};
        end
        `PMW_ADDR_WARN: begin
          s_d.rdata = {24'h00_0000, warn_rd};
        end
        default: begin
          s_d.rdata = `PMW_ZERO32;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q      <= '0;
      s_q.pd_en <= `PMW_PD_EN_RESET;
      s_q.mode <= PMW_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata                 = s_q.rdata;
  assign hreadyout              = 1'b1;
  assign hresp                  = 1'b0;
  assign low_power_run_mode     = s_q.lp_run;
  assign low_power_wait_mode    = s_q.lp_wait;
  assign regulator_standby      = (s_q.mode == PMW_STBY);
  assign stop2_active           = s_q.s2;
  assign stop3_active           = s_q.s3;
  assign detect_voltage_select  = s_q.dsel;
  assign warning_voltage_select = s_q.wsel;
  assign lv_warning_irq         = s_q.irq;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  a_lpr_stop_excl: assert property (@(posedge hclk) disable iff (!hresetn)
    !(s_q.reg_ctrl && s_q.stop_sel))
    else $error("regulator control and stop select both set");

  a_both_set_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_mode && set_stop && wb[`PMW_REG_CTRL_BIT])
    |=> (!s_q.reg_ctrl && s_q.stop_sel))
    else $error("regulator control set by combined write");

  a_irq_clr_reg: assert property (@(posedge hclk) disable iff (!hresetn)
    (irq_s && s_q.wake && !do_wr) |=> !s_q.reg_ctrl)
    else $error("interrupt did not clear regulator control");

  a_stby_status: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.mode == PMW_STBY) |-> $past(s_q.reg_ctrl))
    else $error("standby without regulator control");

  a_stop_needs_en: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(s_q.stop_sel) |-> s_q.pd_en)
    else $error("stop select set without enable");

  a_enable_once: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(s_q.pd_en_locked) |-> $stable(s_q.pd_en))
    else $error("enable changed after first write");

  a_warn_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.wflag && !wr_warn) |=> s_q.wflag)
    else $error("warning flag dropped without acknowledge");

  a_warn_set: assert property (@(posedge hclk) disable iff (!hresetn)
    warn_s |=> s_q.wflag)
    else $error("warning flag not set");

  a_irq_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_d.wflag && s_d.wie) |=> lv_warning_irq)
    else $error("warning interrupt missing");

  a_recov_ack: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_mode && wb[`PMW_RECOV_ACK_BIT] && !wake_s) |=> !s_q.recov)
    else $error("recovery flag not cleared");

endmodule

`default_nettype wire
